// file: design/dml_core.sv
// execution datapath for multiply, or, stack, return, normalize and port output
// assumes an apb master on SYS_CLK and an external port device driving IO_READY
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module dml_core
   import dml_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0,
   parameter int STACK_DEPTH   = 8,
   parameter int DMEM_DEPTH    = 16,
   parameter bit NORMALIZE_ACCUM_COUNT_EN = 1'b1
)
(
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic      [15:0] IO_ADDR,
   output logic      [15:0] IO_DATA,
   output logic             IO_DATA_OE,
   output logic             IO_WE_N,
   output logic             IO_BUS_STROBE_N,
   output logic             IO_IS_N,
   output logic             IO_RW,
   input  wire logic        IO_READY
);

   localparam int AW = $clog2(DMEM_DEPTH);

   // ==========================================================
   // state
   logic [31:0]   acc_q, acc_d, prod_q, prod_d;
   logic [15:0]   mcand_q, mcand_d, bitmr_q, bitmr_d, imm_q, imm_d;
   logic [15:0]   pc_q, pc_d, ret_tgt_q, ret_tgt_d, ncnt_q, ncnt_d;
   logic          carry_q, carry_d, ndone_q, ndone_d;
   logic [1:0]    pm_q, pm_d, dly_q, dly_d;
   logic [15:0]   stack_q [STACK_DEPTH];
   logic [15:0]   stack_d [STACK_DEPTH];
   logic [15:0]   dmem_q  [DMEM_DEPTH];
   logic          stk_push, stk_pop, dmem_we;
   logic [15:0]   stk_val, dmem_wd;
   logic [AW-1:0] dmem_wa;
   logic [31:0]   prdata_d;
   logic          pready_d, pslverr_d;
   dml_io_state_t io_q, io_d;
   logic [15:0]   io_addr_d, io_data_d;
   logic          io_oe_d, io_we_n_d, io_bus_strobe_n_d, io_is_n_d, io_rw_d;
   logic          busy, access, done, wr_done, is_cmd, exec, stall, mapped, in_dmem;
   logic [AW-1:0] apb_idx;

   // ==========================================================
   // apb slave
   // every transfer carries at least one wait state so that read data and the
   // answer come straight from flip-flops
   assign busy    = (io_q != IO_IDLE);
   assign access  = PSEL && PENABLE;
   assign done    = access && PREADY;
   assign wr_done = done && PWRITE;
   assign in_dmem = (PADDR[11:8] == DML_DMEM_PAGE) && (PADDR[1:0] == 2'h0) &&
                    ({24'h0, PADDR[7:2]} < DMEM_DEPTH);
   assign apb_idx = PADDR[2 +: AW];
   assign is_cmd  = (PADDR == DML_CMD_OFS);
   // a new command waits while a port output still holds the bus
   assign stall   = is_cmd && PWRITE && busy;
   assign exec    = wr_done && is_cmd && !PSLVERR;

   always_comb
   begin
      mapped = 1'b1;
      case (PADDR)
         DML_CMD_OFS:   prdata_d = 32'h0;
         DML_IMM_OFS:   prdata_d = {16'h0, imm_q};
         DML_ACC_OFS:   prdata_d = acc_q;
         DML_PROD_OFS:  prdata_d = prod_q;
         DML_MCAND_OFS: prdata_d = {16'h0, mcand_q};
         DML_BITMR_OFS: prdata_d = {16'h0, bitmr_q};
         DML_STAT_OFS:  prdata_d = {26'h0, dly_q != 2'h0, ndone_q, busy, pm_q, carry_q};
         DML_PC_OFS:    prdata_d = {16'h0, pc_q};
         DML_NCNT_OFS:  prdata_d = {16'h0, ncnt_q};
         DML_TOP_OFS:   prdata_d = {16'h0, stack_q[0]};
         default:
         begin
            mapped   = in_dmem;
            prdata_d = in_dmem ? {16'h0, dmem_q[apb_idx]} : 32'h0;
         end
      endcase
      if (!PSEL || PWRITE || !access || PREADY)
      begin
         prdata_d = 32'h0;
      end
      pready_d  = access && !PREADY && !stall;
      pslverr_d = pready_d && !mapped;
   end

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         PRDATA  <= 32'h0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PRDATA  <= prdata_d;
         PREADY  <= pready_d;
         PSLVERR <= pslverr_d;
      end
   end

   // ==========================================================
   // execution
   function automatic logic [31:0] pshift(input logic [31:0] p, input logic [1:0] m);
      case (m)
         DML_PM_LEFT1:  pshift = {p[30:0], 1'b0};
         DML_PM_LEFT4:  pshift = {p[27:0], 4'h0};
         DML_PM_RIGHT6: pshift = {{6{p[31]}}, p[31:6]};
         default:       pshift = p;
      endcase
   endfunction

   logic [4:0]    op;
   logic [3:0]    sh;
   logic [AW-1:0] dma;
   logic [15:0]   mem_rd, opnd, top;
   logic [31:0]   pshifted, sprod, uprod;
   logic [32:0]   sum, diff;
   logic [5:0]    cc, ccmet;
   logic          use_imm, cond_ok, words2;

   assign op       = PWDATA[DML_OP_LSB +: DML_OP_W];
   assign sh       = PWDATA[DML_SH_LSB +: DML_SH_W];
   assign dma      = PWDATA[DML_DMA_LSB +: AW];
   assign cc       = PWDATA[DML_COND_LSB +: DML_COND_W];
   assign words2   = PWDATA[DML_TWOWORD];
   assign use_imm  = PWDATA[DML_USEIMM] && !SMALL_VARIANT;
   assign mem_rd   = dmem_q[dma];
   assign top      = stack_q[0];
   // immediate replaces the memory word only in larger variants
   assign opnd     = !use_imm ? mem_rd :
                     PWDATA[DML_IMM13] ? {{3{imm_q[12]}}, imm_q[12:0]} : imm_q;
   assign sprod    = $signed(mcand_q) * $signed(opnd);
   assign uprod    = {16'h0, mcand_q} * {16'h0, mem_rd};
   assign pshifted = pshift(prod_q, pm_q);
   assign sum      = {1'b0, acc_q} + {1'b0, pshifted};
   assign diff     = {1'b0, acc_q} - {1'b0, pshifted};

   // every specified condition must hold; contradictory masks never return
   assign ccmet[DML_CC_EQ]  = (acc_q == 32'h0);
   assign ccmet[DML_CC_NEQ] = (acc_q != 32'h0);
   assign ccmet[DML_CC_LT]  = acc_q[31];
   assign ccmet[DML_CC_GT]  = !acc_q[31] && (acc_q != 32'h0);
   assign ccmet[DML_CC_C]   = carry_q;
   assign ccmet[DML_CC_NC]  = !carry_q;
   assign cond_ok = ((cc & ~ccmet) == 6'h0);

   always_comb
   begin
      acc_d     = acc_q;
      prod_d    = prod_q;
      mcand_d   = mcand_q;
      bitmr_d   = bitmr_q;
      imm_d     = imm_q;
      pc_d      = pc_q;
      ret_tgt_d = ret_tgt_q;
      ncnt_d    = ncnt_q;
      carry_d   = carry_q;
      ndone_d   = ndone_q;
      pm_d      = pm_q;
      dly_d     = dly_q;
      stk_push  = 1'b0;
      stk_pop   = 1'b0;
      stk_val   = 16'h0;
      dmem_we   = 1'b0;
      dmem_wa   = dma;
      dmem_wd   = 16'h0;
      if (wr_done && !PSLVERR)
      begin
         case (PADDR)
            DML_IMM_OFS:   imm_d   = PWDATA[15:0];
            DML_ACC_OFS:   acc_d   = PWDATA;
            DML_PROD_OFS:  prod_d  = PWDATA;
            DML_MCAND_OFS: mcand_d = PWDATA[15:0];
            DML_BITMR_OFS: bitmr_d = PWDATA[15:0];
            DML_PC_OFS:    pc_d    = PWDATA[15:0];
            DML_NCNT_OFS:  ncnt_d  = PWDATA[15:0];
            DML_STAT_OFS:
            begin
               carry_d = PWDATA[DML_ST_CARRY];
               pm_d    = PWDATA[DML_ST_PM_LSB +: 2];
            end
            default:
            begin
               if (in_dmem)
               begin
                  dmem_we = 1'b1;
                  dmem_wa = apb_idx;
                  dmem_wd = PWDATA[15:0];
               end
            end
         endcase
      end
      if (exec)
      begin
         pc_d = pc_q + (words2 ? 16'h2 : 16'h1);
         // delay slots count instruction words before the pending return
         if (dly_q != 2'h0)
         begin
            if (words2 || dly_q == 2'h1)
            begin
               dly_d = 2'h0;
               pc_d  = ret_tgt_q;
            end
            else
            begin
               dly_d = dly_q - 2'h1;
            end
         end
         case (op)
            DML_OP_MULT:
               prod_d = sprod;
            DML_OP_MULT_ACC:
            begin
               prod_d  = sprod;
               acc_d   = sum[31:0];
               carry_d = sum[32];
            end
            DML_OP_MULT_SUB:
            begin
               prod_d  = sprod;
               acc_d   = diff[31:0];
               carry_d = !diff[32];
            end
            DML_OP_MULT_U:
               prod_d = uprod;
            DML_OP_OR_MEM:
            begin
               dmem_we = 1'b1;
               dmem_wd = mem_rd | (PWDATA[DML_USEIMM] ? imm_q : bitmr_q);
            end
            DML_OP_OR_ACC:
            begin
               if (SMALL_VARIANT)
               begin
                  acc_d = acc_q | {16'h0, mem_rd};
               end
               else
               begin
                  acc_d = acc_q | ({16'h0, opnd} << sh);
               end
            end
            DML_OP_OR_IMM:
               acc_d = acc_q | ({16'h0, imm_q} << sh);
            DML_OP_PROD_ACC:
               acc_d = SMALL_VARIANT ? prod_q : pshifted;
            DML_OP_POP_ACC:
            begin
               acc_d   = {16'h0, SMALL_VARIANT ? (top & DML_SMALL_MASK) : top};
               stk_pop = 1'b1;
            end
            DML_OP_POP_MEM:
            begin
               dmem_we = 1'b1;
               dmem_wd = top;
               stk_pop = 1'b1;
            end
            DML_OP_PUSH_MEM:
            begin
               stk_push = 1'b1;
               stk_val  = mem_rd;
            end
            DML_OP_PUSH_ACC:
            begin
               stk_push = 1'b1;
               stk_val  = SMALL_VARIANT ? (acc_q[15:0] & DML_SMALL_MASK) : acc_q[15:0];
            end
            DML_OP_CLR_C:
               carry_d = 1'b0;
            DML_OP_RET:
            begin
               pc_d    = top;
               stk_pop = 1'b1;
            end
            DML_OP_RET_DLY:
            begin
               ret_tgt_d = top;
               dly_d     = DML_DELAY_WORDS;
               stk_pop   = 1'b1;
            end
            DML_OP_RET_COND:
            begin
               if (cond_ok)
               begin
                  stk_pop = 1'b1;
                  if (PWDATA[DML_CDELAY] && !SMALL_VARIANT)
                  begin
                     ret_tgt_d = top;
                     dly_d     = DML_DELAY_WORDS;
                  end
                  else
                  begin
                     pc_d = top;
                  end
               end
            end
            DML_OP_NORMALIZE_ACCUM:
            begin
               // one step per instruction; software loops until done reads high
               if (acc_q != 32'h0 && acc_q[31] == acc_q[30])
               begin
                  acc_d   = {acc_q[30:0], 1'b0};
                  ndone_d = 1'b0;
                  if (NORMALIZE_ACCUM_COUNT_EN)
                  begin
                     ncnt_d = ncnt_q + 16'h1;
                  end
               end
               else
               begin
                  ndone_d = 1'b1;
               end
            end
            default:
               acc_d = acc_q;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         acc_q     <= 32'h0;
         prod_q    <= 32'h0;
         mcand_q   <= 16'h0;
         bitmr_q   <= 16'h0;
         imm_q     <= 16'h0;
         pc_q      <= DML_PC_RST;
         ret_tgt_q <= 16'h0;
         ncnt_q    <= 16'h0;
         carry_q   <= 1'b0;
         ndone_q   <= 1'b0;
         pm_q      <= DML_PM_NONE;
         dly_q     <= 2'h0;
      end
      else
      begin
         acc_q     <= acc_d;
         prod_q    <= prod_d;
         mcand_q   <= mcand_d;
         bitmr_q   <= bitmr_d;
         imm_q     <= imm_d;
         pc_q      <= pc_d;
         ret_tgt_q <= ret_tgt_d;
         ncnt_q    <= ncnt_d;
         carry_q   <= carry_d;
         ndone_q   <= ndone_d;
         pm_q      <= pm_d;
         dly_q     <= dly_d;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         for (int i = 0; i < DMEM_DEPTH; i++)
         begin
            dmem_q[i] <= 16'h0;
         end
      end
      else if (dmem_we)
      begin
         dmem_q[dmem_wa] <= dmem_wd;
      end
   end

   // ==========================================================
   // hardware stack: bottom entry repeats itself on a pop
   genvar g;
   generate
      for (g = 0; g < STACK_DEPTH; g++)
      begin : g_stk
         always_comb
         begin
            stack_d[g] = stack_q[g];
            if (stk_push)
            begin
               stack_d[g] = (g == 0) ? stk_val : stack_q[(g == 0) ? 0 : g - 1];
            end
            else if (stk_pop)
            begin
               stack_d[g] = stack_q[(g == STACK_DEPTH - 1) ? g : g + 1];
            end
         end
         always_ff @(posedge SYS_CLK or negedge RSTN)
         begin
            if (!RSTN)
            begin
               stack_q[g] <= 16'h0;
            end
            else
            begin
               stack_q[g] <= stack_d[g];
            end
         end
      end
   endgenerate

   // ==========================================================
   // port output
   always_comb
   begin
      io_d        = io_q;
      io_addr_d   = IO_ADDR;
      io_data_d   = IO_DATA;
      io_oe_d     = IO_DATA_OE;
      io_we_n_d   = IO_WE_N;
      io_bus_strobe_n_d = IO_BUS_STROBE_N;
      io_is_n_d   = IO_IS_N;
      io_rw_d     = IO_RW;
      case (io_q)
         IO_IDLE:
         begin
            if (exec && op == DML_OP_OUT)
            begin
               io_data_d = mem_rd;
               io_oe_d   = 1'b1;
               io_rw_d   = 1'b0;
               if (SMALL_VARIANT)
               begin
                  io_addr_d = {13'h0, PWDATA[DML_SH_LSB +: 3]};
                  io_we_n_d = 1'b0;
                  io_d      = IO_SMALL;
               end
               else
               begin
                  io_addr_d   = {12'h0, PWDATA[DML_SH_LSB +: DML_SH_W]};
                  io_is_n_d   = 1'b0;
                  io_bus_strobe_n_d = 1'b0;
                  io_d        = IO_ACCESS;
               end
            end
         end
         IO_SMALL:
         begin
            io_we_n_d = 1'b1;
            io_oe_d   = 1'b0;
            io_rw_d   = 1'b1;
            io_d      = IO_IDLE;
         end
         IO_ACCESS:
         begin
            // the port device stretches the write by holding ready low
            if (IO_READY)
            begin
               io_bus_strobe_n_d = 1'b1;
               io_is_n_d   = 1'b1;
               io_oe_d     = 1'b0;
               io_rw_d     = 1'b1;
               io_d        = IO_IDLE;
            end
         end
         default:
            io_d = IO_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         io_q       <= IO_IDLE;
         IO_ADDR    <= 16'h0;
         IO_DATA    <= 16'h0;
         IO_DATA_OE <= 1'b0;
         IO_WE_N    <= 1'b1;
         IO_BUS_STROBE_N  <= 1'b1;
         IO_IS_N    <= 1'b1;
         IO_RW      <= 1'b1;
      end
      else
      begin
         io_q       <= io_d;
         IO_ADDR    <= io_addr_d;
         IO_DATA    <= io_data_d;
         IO_DATA_OE <= io_oe_d;
         IO_WE_N    <= io_we_n_d;
         IO_BUS_STROBE_N  <= io_bus_strobe_n_d;
         IO_IS_N    <= io_is_n_d;
         IO_RW      <= io_rw_d;
      end
   end

endmodule

// file: design/dml_pkg.sv
// constants shared by the multiply / logic / stack execution block
// assumes an apb master with 32-bit data and byte addressing
package dml_pkg;

   // register byte offsets
   localparam logic [11:0] DML_CMD_OFS    = 12'h000;
   localparam logic [11:0] DML_IMM_OFS    = 12'h004;
   localparam logic [11:0] DML_ACC_OFS    = 12'h008;
   localparam logic [11:0] DML_PROD_OFS   = 12'h00c;
   localparam logic [11:0] DML_MCAND_OFS  = 12'h010;
   localparam logic [11:0] DML_BITMR_OFS  = 12'h014;
   localparam logic [11:0] DML_STAT_OFS   = 12'h018;
   localparam logic [11:0] DML_PC_OFS     = 12'h01c;
   localparam logic [11:0] DML_NCNT_OFS   = 12'h020;
   localparam logic [11:0] DML_TOP_OFS    = 12'h024;
   localparam logic [3:0]  DML_DMEM_PAGE  = 4'h1;

   // command register fields
   localparam int DML_OP_LSB    = 0;
   localparam int DML_OP_W      = 5;
   localparam int DML_SH_LSB    = 5;
   localparam int DML_SH_W      = 4;
   localparam int DML_DMA_LSB   = 9;
   localparam int DML_USEIMM    = 16;
   localparam int DML_IMM13     = 17;
   localparam int DML_TWOWORD   = 18;
   localparam int DML_COND_LSB  = 19;
   localparam int DML_COND_W    = 6;
   localparam int DML_CDELAY    = 25;

   // status register fields
   localparam int DML_ST_CARRY  = 0;
   localparam int DML_ST_PM_LSB = 1;
   localparam int DML_ST_BUSY   = 3;
   localparam int DML_ST_NDONE  = 4;
   localparam int DML_ST_DLY    = 5;

   // opcodes
   localparam logic [4:0] DML_OP_NOP      = 5'h00;
   localparam logic [4:0] DML_OP_MULT     = 5'h01;
   localparam logic [4:0] DML_OP_MULT_ACC = 5'h02;
   localparam logic [4:0] DML_OP_MULT_SUB = 5'h03;
   localparam logic [4:0] DML_OP_MULT_U   = 5'h04;
   localparam logic [4:0] DML_OP_OR_MEM   = 5'h05;
   localparam logic [4:0] DML_OP_OR_ACC   = 5'h06;
   localparam logic [4:0] DML_OP_OR_IMM   = 5'h07;
   localparam logic [4:0] DML_OP_OUT      = 5'h08;
   localparam logic [4:0] DML_OP_PROD_ACC = 5'h09;
   localparam logic [4:0] DML_OP_POP_ACC  = 5'h0a;
   localparam logic [4:0] DML_OP_POP_MEM  = 5'h0b;
   localparam logic [4:0] DML_OP_PUSH_MEM = 5'h0c;
   localparam logic [4:0] DML_OP_PUSH_ACC = 5'h0d;
   localparam logic [4:0] DML_OP_CLR_C    = 5'h0e;
   localparam logic [4:0] DML_OP_RET      = 5'h0f;
   localparam logic [4:0] DML_OP_RET_DLY  = 5'h10;
   localparam logic [4:0] DML_OP_RET_COND = 5'h11;
   localparam logic [4:0] DML_OP_NORMALIZE_ACCUM     = 5'h12;

   // product shift modes
   localparam logic [1:0] DML_PM_NONE   = 2'h0;
   localparam logic [1:0] DML_PM_LEFT1  = 2'h1;
   localparam logic [1:0] DML_PM_LEFT4  = 2'h2;
   localparam logic [1:0] DML_PM_RIGHT6 = 2'h3;

   // condition mask bits for conditional return
   localparam int DML_CC_EQ  = 0;
   localparam int DML_CC_NEQ = 1;
   localparam int DML_CC_LT  = 2;
   localparam int DML_CC_GT  = 3;
   localparam int DML_CC_C   = 4;
   localparam int DML_CC_NC  = 5;

   localparam logic [1:0]  DML_DELAY_WORDS = 2'h2;
   localparam logic [15:0] DML_SMALL_MASK  = 16'h0fff;
   localparam logic [15:0] DML_PC_RST      = 16'h0000;

   typedef enum logic [1:0] {IO_IDLE, IO_SMALL, IO_ACCESS} dml_io_state_t;

endpackage

// file: tb/dml_core_monitor.sv
// checker for the port output and register bus timing of the execution block
// assumes the larger variant and is bound to every dml_core instance
`timescale 1ns/10ps
module dml_core_monitor (
   input wire logic        SYS_CLK, RSTN, PSEL, PENABLE, PREADY, PSLVERR,
   input wire logic [31:0] PRDATA,
   input wire logic [15:0] IO_DATA,
   input wire logic        IO_DATA_OE, IO_WE_N, IO_BUS_STROBE_N, IO_IS_N, IO_RW, IO_READY
);
   // ==========================================
   // properties
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   bus_strobe_io_sel_a: assert property (IO_BUS_STROBE_N == IO_IS_N)
      else $error("io select differs from strobe");
   wr_drive_a: assert property (!IO_BUS_STROBE_N |-> !IO_RW && IO_DATA_OE)
      else $error("port write not driving");
   bus_strobe_end_a: assert property (!IO_BUS_STROBE_N && IO_READY |=> IO_BUS_STROBE_N)
      else $error("strobe kept after ready");
   bus_strobe_wait_a: assert property (!IO_BUS_STROBE_N && !IO_READY |=> !IO_BUS_STROBE_N)
      else $error("strobe dropped without ready");
   we_idle_a: assert property (IO_WE_N)
      else $error("write enable used in larger variant");
   data_hold_a: assert property (!IO_BUS_STROBE_N |=> IO_BUS_STROBE_N || $stable(IO_DATA))
      else $error("port data moved during access");
   bus_free_a: assert property ($rose(IO_BUS_STROBE_N) |-> !IO_DATA_OE && IO_RW)
      else $error("bus not released");
   apb_wait_a: assert property (PSEL && $rose(PENABLE) && IO_BUS_STROBE_N |-> !PREADY ##1 PREADY)
      else $error("wrong wait state count");
   rd_zero_a: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside completion");
   err_valid_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   cover property (!IO_BUS_STROBE_N && !IO_READY ##1 IO_READY);
   cover property (PREADY && PSLVERR);
   cover property ($fell(IO_BUS_STROBE_N));
endmodule
bind dml_core dml_core_monitor mon (.*);

// file: tb/dml_port_model.sv
// port device on the external bus: answers with ready after wait_cyc strobe cycles
// assumes the block drives strobe and io select low together
`timescale 1ns/10ps
module dml_port_model (
   input wire logic        clk, rstn, bus_strobe_n, is_n,
   input wire logic [15:0] addr, data,
   input wire logic [3:0]  wait_cyc,
   output logic            ready,
   output logic     [15:0] got_data, got_addr
);
   logic [3:0] cnt_q;
   logic       tog_q;
   // ==========================================
   // unselected ready toggles so a stale level is never trusted
   assign ready = (bus_strobe_n | is_n) ? tog_q : (cnt_q >= wait_cyc);
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         {cnt_q, tog_q, got_data, got_addr} <= '0;
      else
      begin
         tog_q <= ~tog_q;
         cnt_q <= (bus_strobe_n | is_n) ? 4'h0 : cnt_q + 4'h1;
         if (!bus_strobe_n && !is_n && ready)
         begin
            got_data <= data;
            got_addr <= addr;
         end
      end
endmodule

// file: tb/dml_tb.sv
// self-checking bench: apb register accesses issue instructions and read results
// assumes the larger variant with default parameters
`timescale 1ns/10ps
module tb;
   import dml_pkg::*;
   logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
   logic [11:0] pa = 12'h0;
   logic [31:0] pwd = 32'h0, prd, rv;
   logic        pre, perr, serr, oe, we_n, bus_strobe_n, is_n, rw, rdy;
   logic [15:0] ioa, iod, got_d, got_a;
   logic [3:0]  wt = 4'h3;
   int          error_cnt = 0, cmp_count = 0;
   initial forever #25 clk = ~clk;
   dml_core DUT (.SYS_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pre), .PSLVERR(perr), .IO_ADDR(ioa),
      .IO_DATA(iod), .IO_DATA_OE(oe), .IO_WE_N(we_n), .IO_BUS_STROBE_N(bus_strobe_n), .IO_IS_N(is_n),
      .IO_RW(rw), .IO_READY(rdy));
   dml_port_model port (.clk(clk), .rstn(rstn), .bus_strobe_n(bus_strobe_n), .is_n(is_n), .addr(ioa),
      .data(iod), .wait_cyc(wt), .ready(rdy), .got_data(got_d), .got_addr(got_a));
   // ==========================================
   // bus tasks
   task conclude;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      // one free edge between transfers: psel is never assigned twice in one step
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do @(posedge clk); while (pre !== 1'b1 && ++n < 300);
      rv = prd;
      serr = perr;
      psel <= 0;
      pen <= 0;
      if (n >= 300)
      begin
         error_cnt++;
         conclude();
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
   task rd(input logic [11:0] a, input logic [31:0] e); apb(0, a, 32'h0); chk(rv, e); endtask
   task x(input logic [31:0] d); apb(1, DML_CMD_OFS, d); endtask
   function automatic logic [31:0] c(logic [4:0] op, logic [3:0] sh = 4'h0, ix = 4'h0,
      logic u = 1'b0);
      c = {15'h0, u, 3'h0, ix, sh, op};
   endfunction
   // ==========================================
   // scenarios
   initial
   begin
      int n;
      repeat (10) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      wr(DML_MCAND_OFS, 32'h3);
      wr(12'h100, 32'hfffe);
      x(c(DML_OP_MULT));
      rd(DML_PROD_OFS, 32'hfffffffa);
      wr(DML_IMM_OFS, 32'h5);
      x(c(DML_OP_MULT, 4'h0, 4'h0, 1'b1));
      rd(DML_PROD_OFS, 32'hf);
      wr(DML_ACC_OFS, 32'h10);
      x(c(DML_OP_MULT_ACC));
      rd(DML_ACC_OFS, 32'h1f);
      wr(DML_STAT_OFS, 32'h2);
      x(c(DML_OP_MULT_SUB));
      rd(DML_ACC_OFS, 32'h2b);
      x(c(DML_OP_MULT_U));
      rd(DML_PROD_OFS, 32'h2fffa);
      x(c(DML_OP_PROD_ACC));
      rd(DML_ACC_OFS, 32'h5fff4);
      wr(DML_BITMR_OFS, 32'h101);
      wr(12'h104, 32'h1010);
      x(c(DML_OP_OR_MEM, 4'h0, 4'h1));
      rd(12'h104, 32'h1111);
      wr(DML_IMM_OFS, 32'h8000);
      x(c(DML_OP_OR_MEM, 4'h0, 4'h1, 1'b1));
      rd(12'h104, 32'h9111);
      wr(DML_ACC_OFS, 32'hffff0000);
      x(c(DML_OP_OR_ACC, 4'h4, 4'h1));
      rd(DML_ACC_OFS, 32'hffff1110);
      wr(DML_IMM_OFS, 32'h8001);
      wr(DML_ACC_OFS, 32'h0);
      x(c(DML_OP_OR_IMM, 4'hf));
      rd(DML_ACC_OFS, 32'h40008000);
      wr(DML_ACC_OFS, 32'h12345);
      x(c(DML_OP_PUSH_ACC));
      rd(DML_TOP_OFS, 32'h2345);
      x(c(DML_OP_PUSH_MEM, 4'h0, 4'h1));
      rd(DML_TOP_OFS, 32'h9111);
      x(c(DML_OP_POP_MEM, 4'h0, 4'h2));
      rd(12'h108, 32'h9111);
      wr(DML_ACC_OFS, 32'hffffffff);
      x(c(DML_OP_POP_ACC));
      rd(DML_ACC_OFS, 32'h2345);
      wr(DML_STAT_OFS, 32'h1);
      x(c(DML_OP_CLR_C));
      rd(DML_STAT_OFS, 32'h0);
      wr(DML_ACC_OFS, 32'h40);
      x(c(DML_OP_PUSH_ACC));
      x(c(DML_OP_RET));
      rd(DML_PC_OFS, 32'h40);
      wr(DML_ACC_OFS, 32'h80);
      x(c(DML_OP_PUSH_ACC));
      wr(DML_PC_OFS, 32'h20);
      x(c(DML_OP_RET_DLY));
      rd(DML_PC_OFS, 32'h21);
      x(c(DML_OP_NOP));
      x(c(DML_OP_NOP));
      rd(DML_PC_OFS, 32'h80);
      x(c(DML_OP_PUSH_ACC));
      wr(DML_PC_OFS, 32'h60);
      x(c(DML_OP_RET_DLY));
      x(c(DML_OP_NOP) | 32'h40000);
      rd(DML_PC_OFS, 32'h80);
      wr(DML_ACC_OFS, 32'h30);
      x(c(DML_OP_PUSH_ACC));
      wr(DML_ACC_OFS, 32'h0);
      wr(DML_PC_OFS, 32'h50);
      x(c(DML_OP_RET_COND) | 32'h100000);
      rd(DML_PC_OFS, 32'h51);
      x(c(DML_OP_RET_COND) | 32'h80000);
      rd(DML_PC_OFS, 32'h30);
      wr(DML_ACC_OFS, 32'h10000000);
      x(c(DML_OP_NORMALIZE_ACCUM));
      rd(DML_ACC_OFS, 32'h20000000);
      rd(DML_NCNT_OFS, 32'h1);
      wr(12'h10c, 32'ha5c3);
      wr(12'h110, 32'h5a3c);
      x(c(DML_OP_OUT, 4'h5, 4'h3));
      // second output stalls on the bus until the slow first one ends
      x(c(DML_OP_OUT, 4'h9, 4'h4));
      wt <= 4'h0;
      chk(got_d, 32'ha5c3);
      chk(got_a, 32'h5);
      // the strobe of the second output falls on the edge that ended the command write, not yet visible here
      @(posedge clk);
      for (n = 0; n < 50 && bus_strobe_n !== 1'b1; n++) @(posedge clk);
      if (n == 50)
         error_cnt++;
      @(posedge clk);
      chk(got_d, 32'h5a3c);
      rd(12'h0fc, 32'h0);
      chk(serr, 32'h1);
      conclude();
   end
endmodule
